// [design/pars_sequencer.sv]
// rolling-shutter readout sequencer: row reset and row read pointers, pixel stream
// assumes window values are stable while frameStart is low; controls from same clock
`timescale 1ns/10ps
module pars_sequencer
#(
  parameter int ADDR_W = pars_pkg::ADDR_W,
  parameter int INC_W  = pars_pkg::INC_W,
  parameter int PIX_W  = 10
)
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              streamEnable,
  input  wire logic              globalResetMode,
  input  wire logic              captureTrigger,
  input  wire logic              shutterDone,
  input  wire logic [15:0]       exposureLines,
  input  wire logic [ADDR_W-1:0] xAddrStart,
  input  wire logic [ADDR_W-1:0] xAddrEnd,
  input  wire logic [ADDR_W-1:0] yAddrStart,
  input  wire logic [ADDR_W-1:0] yAddrEnd,
  input  wire logic [ADDR_W-1:0] xOutputSize,
  input  wire logic [ADDR_W-1:0] yOutputSize,
  input  wire logic [INC_W-1:0]  xOddInc,
  input  wire logic [INC_W-1:0]  yOddInc,
  input  wire logic              columnReverse,
  input  wire logic              rowReverse,
  input  wire logic [PIX_W-1:0]  arrayData,
  input  wire logic              hostReady,
  output logic [ADDR_W-1:0]      arrayColumn,
  output logic [ADDR_W-1:0]      arrayReadRow,
  output logic [ADDR_W-1:0]      arrayResetRow,
  output logic                   rowResetStrobe,
  output logic                   rowReadStrobe,
  output logic                   globalResetPulse,
  output logic                   shutterOpen,
  output logic [PIX_W-1:0]       pixelData,
  output logic                   pixelValid,
  output logic                   lineStart,
  output logic                   frameStart,
  output logic [1:0]             colourPhase,
  output logic                   incSettingError
);
  // ***************************************
  // helpers
  // ***************************************
  function automatic logic incLegal(input logic [INC_W-1:0] inc);
    incLegal = (inc == pars_pkg::INC_ONE) || (inc == pars_pkg::INC_THREE) || (inc == pars_pkg::INC_SEVEN);
  endfunction

  // pairs: odd address jumps by increment, even steps by one; reversed, even address jumps and odd steps by one
  function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a, input logic [INC_W-1:0] inc,
                                                 input logic down);
    logic [ADDR_W-1:0] fwd;
    fwd = (a[0] == down) ? pars_pkg::PAIR_STEP : ADDR_W'(inc);
    stepAddr = down ? (a - fwd) : (a + fwd);
  endfunction

  // first address of a walk: the high end when that axis runs reversed
  function automatic logic [ADDR_W-1:0] pickEdge(input logic [ADDR_W-1:0] low, input logic [ADDR_W-1:0] high,
                                                 input logic rev);
    pickEdge = rev ? high : low;
  endfunction

  // ***************************************
  // frame-latched settings
  // ***************************************
  pars_pkg::pars_state_t state;
  pars_pkg::pars_state_t next_state;
  logic [ADDR_W-1:0] fxs, fxe, fys, fye, fxSize, fySize;
  logic [INC_W-1:0]  fxInc, fyInc;
  logic              fColRev, fRowRev;
  logic [15:0]       fExpo;
  logic [15:0]       lineCount;
  logic [ADDR_W-1:0] colCount, rowsOut;
  logic              resetsDone;

  wire incOk        = incLegal(xOddInc) && incLegal(yOddInc);
  wire [INC_W-1:0] xIncUse = incLegal(xOddInc) ? xOddInc : pars_pkg::INC_ONE;
  wire [INC_W-1:0] yIncUse = incLegal(yOddInc) ? yOddInc : pars_pkg::INC_ONE;
  wire [ADDR_W-1:0] rowFirst = pickEdge(fys, fye, fRowRev);
  wire [ADDR_W-1:0] rowLast  = pickEdge(fye, fys, fRowRev);
  wire [ADDR_W-1:0] colFirst = pickEdge(fxs, fxe, fColRev);
  wire [ADDR_W-1:0] colLast  = pickEdge(fxe, fxs, fColRev);
  wire lineBeat     = (state == pars_pkg::PARS_ROW) && hostReady;
  wire lineEnd      = lineBeat && ((arrayColumn == colLast) || (colCount == fxSize - 12'h001));
  wire readPhase    = lineCount >= fExpo;
  wire frameEnd     = lineEnd && ((arrayReadRow == rowLast) || (rowsOut == fySize - 12'h001));
  wire startFrame   = (state == pars_pkg::PARS_IDLE) && streamEnable && !globalResetMode && incOk;
  wire startGlobal  = (state == pars_pkg::PARS_IDLE) && globalResetMode && captureTrigger && incOk;
  wire resetAdvance = (state == pars_pkg::PARS_ROW || state == pars_pkg::PARS_GAP) && lineStart && !resetsDone;
  wire shutterClose = (state == pars_pkg::PARS_SHUT) && shutterDone;

  // ***************************************
  // state sequencing
  // ***************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      pars_pkg::PARS_IDLE:
      begin
        if (startGlobal)
          next_state = pars_pkg::PARS_SHUT;
        else if (startFrame)
          next_state = pars_pkg::PARS_GAP;
      end
      pars_pkg::PARS_GAP:
      begin
        if (readPhase)
          next_state = pars_pkg::PARS_ROW;
      end
      pars_pkg::PARS_ROW:
      begin
        if (frameEnd)
          next_state = pars_pkg::PARS_FLUSH;
      end
      pars_pkg::PARS_SHUT:
      begin
        if (shutterDone)
          next_state = pars_pkg::PARS_ROW;
      end
      pars_pkg::PARS_FLUSH:
      begin
        next_state = pars_pkg::PARS_IDLE;
      end
      default:
        next_state = pars_pkg::PARS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state <= pars_pkg::PARS_IDLE;
    else
      state <= next_state;
  end

  // settings change only between frames so a frame is uniform
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fxs <= pars_pkg::X_START_RST;
      fxe <= pars_pkg::X_END_RST;
      fys <= pars_pkg::Y_START_RST;
      fye <= pars_pkg::Y_END_RST;
      fxSize <= pars_pkg::X_SIZE_RST;
      fySize <= pars_pkg::Y_SIZE_RST;
      fxInc <= pars_pkg::INC_ONE;
      fyInc <= pars_pkg::INC_ONE;
      fColRev <= 1'b0;
      fRowRev <= 1'b0;
      fExpo <= pars_pkg::EXPO_RST;
    end
    else if (startFrame || startGlobal)
    begin
      fxs <= xAddrStart;
      fxe <= xAddrEnd;
      fys <= yAddrStart;
      fye <= yAddrEnd;
      fxSize <= xOutputSize;
      fySize <= yOutputSize;
      fxInc <= xIncUse;
      fyInc <= yIncUse;
      fColRev <= columnReverse;
      fRowRev <= rowReverse;
      fExpo <= exposureLines;
    end
  end

  // ***************************************
  // row pointers: reset leads read by a fixed count
  // ***************************************
  wire holdPointers = (state == pars_pkg::PARS_IDLE) || (state == pars_pkg::PARS_SHUT);
  wire readRowLoad  = (state == pars_pkg::PARS_GAP) && readPhase;
  wire [ADDR_W-1:0] resetRowFirst = pickEdge(yAddrStart, yAddrEnd, rowReverse);

  // reset pointer runs ahead of the read pointer by the exposure count plus two row steps
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arrayResetRow <= '0;
      resetsDone <= 1'b0;
    end
    else if (holdPointers)
    begin
      arrayResetRow <= startFrame ? resetRowFirst : arrayResetRow;
      resetsDone <= state == pars_pkg::PARS_SHUT;
    end
    else if (resetAdvance)
    begin
      resetsDone <= arrayResetRow == rowLast;
      arrayResetRow <= stepAddr(arrayResetRow, fyInc, fRowRev);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || holdPointers)
      lineCount <= '0;
    else if (lineStart)
      lineCount <= lineCount + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arrayReadRow <= '0;
      rowsOut <= '0;
    end
    else if (holdPointers || readRowLoad)
    begin
      arrayReadRow <= rowFirst;
      rowsOut <= '0;
    end
    else if (lineEnd)
    begin
      arrayReadRow <= stepAddr(arrayReadRow, fyInc, fRowRev);
      rowsOut <= rowsOut + 12'h001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arrayColumn <= '0;
      colCount <= '0;
    end
    else if (holdPointers || readRowLoad)
    begin
      arrayColumn <= colFirst;
      colCount <= '0;
    end
    else if (lineBeat)
    begin
      arrayColumn <= lineEnd ? colFirst : stepAddr(arrayColumn, fxInc, fColRev);
      colCount <= lineEnd ? '0 : colCount + 12'h001;
    end
  end

  // ***************************************
  // strobes and pixel stream
  // ***************************************
  wire [ADDR_W-1:0] firstColumn = pickEdge(xAddrStart, xAddrEnd, columnReverse);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pixelData <= '0;
      pixelValid <= 1'b0;
    end
    else
    begin
      pixelData <= lineBeat ? arrayData : pixelData;
      pixelValid <= lineBeat;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lineStart <= 1'b0;
      frameStart <= 1'b0;
      rowReadStrobe <= 1'b0;
    end
    else
    begin
      lineStart <= (state == pars_pkg::PARS_GAP) || lineEnd;
      frameStart <= readRowLoad || shutterClose;
      rowReadStrobe <= lineEnd;
    end
  end

  // shutter control for single-frame capture
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      globalResetPulse <= 1'b0;
      shutterOpen <= 1'b0;
    end
    else
    begin
      globalResetPulse <= startGlobal;
      shutterOpen <= (state == pars_pkg::PARS_SHUT) && !shutterDone;
    end
  end

  // parity of the first output pixel gives the colour order
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      colourPhase <= pars_pkg::PHASE_RST;
      incSettingError <= 1'b0;
    end
    else
    begin
      colourPhase <= {resetRowFirst[0], firstColumn[0]};
      incSettingError <= !incOk;
    end
  end

  assign rowResetStrobe = resetAdvance;
endmodule

// [design/pars_pkg.sv]
// constants and types for the pixel array readout sequencer
// assumes a single clock and synchronous active-low reset at the top
//
// Behaviour
// - rolling shutter resets then reads each row
// - reset-to-read interval equal only for rows reset once readout runs; earlier rows reset one per cycle
// - new exposure applied only at frame start
// - global reset mode captures one frame, shutter
// - sequencing confined to programmed address window
// - output frame sized by output width, height
// - reset window is 2048 by 1536
// - column reverse reads last to first column
// - row reverse reads last to first row
// - colour phase follows orientation bits
// - odd increment accepts only 1, 3, 7
// - increment 3 gives two-by-two skipping
// - increment 7 gives four-by-four skipping
// - skipping visits addresses in adjacent pairs
package pars_pkg;
  localparam int ADDR_W = 12;
  localparam int INC_W  = 3;
  localparam logic [ADDR_W-1:0] X_START_RST = 12'h008;
  localparam logic [ADDR_W-1:0] Y_START_RST = 12'h008;
  localparam logic [ADDR_W-1:0] X_END_RST   = 12'h807;
  localparam logic [ADDR_W-1:0] Y_END_RST   = 12'h607;
  localparam logic [ADDR_W-1:0] X_SIZE_RST  = 12'h800;
  localparam logic [ADDR_W-1:0] Y_SIZE_RST  = 12'h600;
  localparam logic [INC_W-1:0]  INC_ONE   = 3'h1;
  localparam logic [INC_W-1:0]  INC_THREE = 3'h3;
  localparam logic [INC_W-1:0]  INC_SEVEN = 3'h7;
  localparam logic [ADDR_W-1:0] PAIR_STEP = 12'h001;
  localparam logic [1:0]        PHASE_RST = 2'h0;
  localparam logic [15:0]       EXPO_RST  = 16'h0010;
  typedef enum logic [2:0] {PARS_IDLE, PARS_ROW, PARS_GAP, PARS_SHUT, PARS_FLUSH} pars_state_t;
endpackage

// [testbench/pars_props.sv]
// assertions on the readout sequencer ports
// assumes window settings are held still while frames run
`timescale 1ns/10ps
module pars_props
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hostReady,
  input wire logic        globalResetMode,
  input wire logic        shutterDone,
  input wire logic [11:0] yAddrStart,
  input wire logic [11:0] yAddrEnd,
  input wire logic [11:0] arrayReadRow,
  input wire logic [11:0] arrayResetRow,
  input wire logic        rowResetStrobe,
  input wire logic        rowReadStrobe,
  input wire logic        globalResetPulse,
  input wire logic        shutterOpen,
  input wire logic        pixelValid,
  input wire logic        frameStart,
  input wire logic        incSettingError
);
  // ********************
  // port relations
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_closing;
    shutterOpen && shutterDone;
  endsequence
  sequence s_opening;
    ##1 shutterOpen;
  endsequence
  a_capture_opens: assert property (globalResetPulse |-> s_opening)
    else $error("shutter not opened after capture start");
  a_line_read_pixel: assert property (rowReadStrobe |-> pixelValid)
    else $error("row read strobe without last pixel");
  a_pixel_after_ready: assert property (pixelValid |-> $past(hostReady))
    else $error("pixel without ready");
  a_error_no_frame: assert property (incSettingError |-> !frameStart)
    else $error("frame despite bad increment");
  a_frame_pulse_once: assert property (frameStart |=> !frameStart)
    else $error("frame start held");
  a_read_row_window: assert property (pixelValid |-> $past(arrayReadRow) inside {[yAddrStart:yAddrEnd]})
    else $error("read row outside window");
  a_reset_row_window: assert property (rowResetStrobe |-> arrayResetRow inside {[yAddrStart:yAddrEnd]})
    else $error("reset row outside window");
  a_shutter_mode: assert property ($rose(shutterOpen) |-> globalResetMode)
    else $error("shutter opened outside capture mode");
  a_shutter_close: assert property (s_closing |-> ##[1:3] !shutterOpen)
    else $error("shutter stays open");
  a_dark_while_open: assert property (shutterOpen |-> !pixelValid)
    else $error("pixels during exposure");
endmodule
bind pars_sequencer pars_props i_props (.*);

// [testbench/pars_host_model.sv]
// host model taking the pixel stream, keeps the last complete frame
// assumes one pixel per valid cycle
`timescale 1ns/10ps
module pars_host_model
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       stallOn,
  input  wire logic       pixelValid,
  input  wire logic [9:0] pixelData,
  input  wire logic       frameStart,
  output logic            hostReady
);
  logic [9:0] cur[$];
  logic [9:0] prev[$];
  int         frames = 0;
  logic [1:0] phase = 2'h0;
  // stalls one cycle in four when asked
  assign hostReady = !stallOn || phase != 2'h3;
  always @(posedge clock)
  begin
    if (!rst_n)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
    if (frameStart)
    begin
      prev = cur;
      cur.delete();
      frames++;
    end
    if (pixelValid)
      cur.push_back(pixelData);
  end
endmodule

// [testbench/pars_sequencer_bench.sv]
// self-checking bench for the readout sequencer
// assumes array data carries its own row and column address
`timescale 1ns/10ps
module pars_sequencer_bench;
  logic        clock = 1'b0, rst_n = 1'b0, streamEnable = 1'b0, globalResetMode = 1'b0, stallOn = 1'b0;
  logic        captureTrigger = 1'b0, shutterDone = 1'b0, columnReverse = 1'b0, rowReverse = 1'b0;
  logic        hostReady, rowResetStrobe, rowReadStrobe, globalResetPulse, shutterOpen;
  logic        pixelValid, lineStart, frameStart, incSettingError;
  logic [15:0] exposureLines = 16'h0004;
  logic [11:0] xAddrStart = 12'h008, xAddrEnd = 12'h00f, yAddrStart = 12'h008, yAddrEnd = 12'h00b;
  logic [11:0] xOutputSize = 12'h008, yOutputSize = 12'h004, arrayColumn, arrayReadRow, arrayResetRow;
  logic [2:0]  xOddInc = 3'h1, yOddInc = 3'h1;
  logic [9:0]  arrayData, pixelData;
  logic [1:0]  colourPhase;
  int          n_errors = 0, total_checks = 0;
  assign arrayData = {arrayReadRow[3:0], arrayColumn[5:0]};
  always #4 clock = ~clock;
  pars_sequencer i_dut (.*);
  pars_host_model i_host (.*);
  // ********************
  // access tasks
  // ********************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bound(input int k);
    if (k >= 6000)
    begin
      check(0, 1, "timeout");
      end_sim();
    end
  endtask
  task automatic cmpFrame(input logic [9:0] got[$], input logic [9:0] exp[$]);
    int bad = 0;
    check(got.size(), exp.size(), "pixels per frame");
    foreach (exp[i]) bad += (i < got.size() && got[i] === exp[i]) ? 0 : 1;
    check(bad, 0, "pixel order");
  endtask
  // addresses step in pairs, a reversed walk mirrors the forward one
  function automatic void walk(input int s, input int e, input int inc, input bit rev, ref int q[$]);
    q.delete();
    for (int a = s; a <= e; a += (a % 2 == 1) ? inc : 1)
      if (rev)
        q.push_front(a);
      else
        q.push_back(a);
  endfunction
  task automatic runFrames(input int xe, input int ye, input int inc, input bit cr, input bit rr, input bit g,
                           input int wcut = 0);
    int cols[$], rows[$], k, f0, q;
    logic [9:0] exp[$];
    walk(8, xe, inc, cr, cols);
    walk(8, ye, inc, rr, rows);
    foreach (rows[r])
      foreach (cols[c])
        if (c < cols.size() - wcut)
          exp.push_back(10'(rows[r] % 16 * 64 + cols[c] % 64));
    xAddrEnd = 12'(xe);
    yAddrEnd = 12'(ye);
    xOddInc = 3'(inc);
    yOddInc = 3'(inc);
    xOutputSize = 12'(cols.size() - wcut);
    yOutputSize = 12'(rows.size());
    columnReverse = cr;
    rowReverse = rr;
    stallOn = cr;
    globalResetMode = g;
    f0 = i_host.frames;
    tick(1);
    if (g)
    begin
      captureTrigger = 1'b1;
      for (k = 0; k < 6000 && !shutterOpen; k++) tick(1);
      bound(k);
      captureTrigger = 1'b0;
      tick(5);
      shutterDone = 1'b1;
      tick(1);
      shutterDone = 1'b0;
      for (k = 0; k < 6000 && (i_host.frames == f0 || i_host.cur.size() < exp.size()); k++) tick(1);
    end
    else
    begin
      streamEnable = 1'b1;
      for (k = 0; k < 6000 && i_host.frames < f0 + 2; k++) tick(1);
      bound(k);
      cmpFrame(i_host.prev, exp);
      for (k = 0; k < 6000 && i_host.frames < f0 + 3; k++) tick(1);
      streamEnable = 1'b0;
      cmpFrame(i_host.prev, exp);
    end
    bound(k);
    q = 0;
    for (k = 0; k < 6000 && q < 40; k++)
    begin
      tick(1);
      q = (pixelValid || lineStart || shutterOpen) ? 0 : q + 1;
    end
    bound(k);
    if (g)
    begin
      cmpFrame(i_host.cur, exp);
      check(i_host.frames - f0, 1, "single capture");
    end
    check(colourPhase, rows[0] % 2 * 2 + cols[0] % 2, "colour phase");
    check(incSettingError, 0, "increment accepted");
    globalResetMode = 1'b0;
    $display("test done at %0t", $time);
  endtask
  // ********************
  // test sequence
  // ********************
  initial
  begin
    int f0;
    tick(8);
    rst_n = 1'b1;
    tick(1);
    check(colourPhase, pars_pkg::PHASE_RST, "reset phase");
    runFrames(15, 11, 1, 0, 0, 0);
    runFrames(15, 11, 1, 1, 0, 0);
    runFrames(15, 11, 1, 0, 1, 0);
    runFrames(15, 11, 1, 0, 0, 0, 2);
    runFrames(13, 13, 3, 0, 0, 0);
    runFrames(17, 17, 7, 1, 1, 0);
    runFrames(15, 11, 1, 0, 0, 1);
    xOddInc = 3'h2;
    f0 = i_host.frames;
    streamEnable = 1'b1;
    tick(60);
    check(incSettingError, 1, "increment error");
    check(i_host.frames - f0, 0, "refused frame");
    streamEnable = 1'b0;
    $display("test done at %0t", $time);
    end_sim();
  end
endmodule
